//--- logic/cssb_params.svh
`ifndef CSSB_PARAMS_SVH
`define CSSB_PARAMS_SVH

`define CSSB_OP_SEL_BANK0 8'h4f
`define CSSB_OP_SEL_BANK1 8'h5f
`define CSSB_OP_SBC_R_R 8'h32
`define CSSB_OP_SBC_R_IR 8'h33
`define CSSB_OP_SBC_G_G 8'h34
`define CSSB_OP_SBC_G_IG 8'h35
`define CSSB_OP_SBC_G_IM 8'h36
`define CSSB_OP_SET_CARRY 8'hdf
`define CSSB_OP_ASR_G 8'hd0
`define CSSB_OP_ASR_IG 8'hd1
`define CSSB_OP_LOAD_PTR 8'h31
`define CSSB_OP_STOP 8'h7f

`define CSSB_ADDR_FLAGS 8'hd5
`define CSSB_ADDR_RP0 8'hd6
`define CSSB_ADDR_RP1 8'hd7
`define CSSB_ADDR_UNLOCK 8'hfb

`define CSSB_UNLOCK_KEY 8'ha5
`define CSSB_WREG_HI 4'hc
`define CSSB_SET1_HI 2'h3

`define CSSB_FLAG_C 7
`define CSSB_FLAG_Z 6
`define CSSB_FLAG_S 5
`define CSSB_FLAG_V 4
`define CSSB_FLAG_D 3
`define CSSB_FLAG_H 2
`define CSSB_FLAG_BANK 0

`define CSSB_RST_FLAGS 8'h00
`define CSSB_RST_RP0 8'hc0
`define CSSB_RST_RP1 8'hc8
`define CSSB_RST_UNLOCK 8'h00

`define CSSB_CYC_SHORT 4'h4
`define CSSB_CYC_LONG 4'h6

`endif

//--- logic/cssb_pkg.sv
`default_nettype none
package cssb_pkg;

  typedef enum logic [3:0] {
    st_idle,
    st_ind,
    st_ind_cap,
    st_src,
    st_src_cap,
    st_dst,
    st_dst_cap,
    st_wb,
    st_hold,
    st_stopped
  } cssb_state_t;

  typedef logic [7:0] cssb_byte_t;

endpackage : cssb_pkg
`default_nettype wire

//--- logic/cssb_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cssb_mem_if #(
  parameter int AW = 9
);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;

  modport ctrl(output we, waddr, wdata, re, raddr, input rdata);
  modport store(input we, waddr, wdata, re, raddr, output rdata);
endinterface : cssb_mem_if
`default_nettype wire

//--- logic/cssb_regmem.sv
`timescale 1ns/10ps
`default_nettype none
module cssb_regmem #(
  parameter int AW = 9
) (
  input wire logic clk,
  cssb_mem_if.store mp
);
  logic [7:0] mem_q [0:(1<<AW)-1];
  logic [7:0] rdata_q;

  // register file contents survive reset, as stop mode requires
  always_ff @(posedge clk) begin
    if (mp.we) begin
      mem_q[mp.waddr] <= mp.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (mp.re) begin
      rdata_q <= mem_q[mp.raddr];
    end
  end

  assign mp.rdata = rdata_q;
endmodule : cssb_regmem
`default_nettype wire

//--- logic/cssb_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "cssb_params.svh"
// Summary of operation
// RL1 - bank zero op clears flag bit 0
// RL2 - bank one op sets flag bit 0
// RL3 - bank flag steers set 1 accesses
// RL4 - borrow subtract: dst minus src minus carry
// RL5 - carry set on borrow, else cleared
// RL6 - zero and sign follow the result
// RL7 - overflow on signed subtract overflow
// RL8 - decimal flag forced; half flag marks nibble borrow
// RL9 - set carry op forces carry only
// RL10 - arithmetic shift keeps sign, old bit0 to carry
// RL11 - shift sets carry from old bit0, zero and sign from result
// RL12 - shift clears overflow, keeps decimal, half
// RL13 - pointer load by source bits 1:0
// RL14 - code 00 loads both pointers, bit3 fixed
// RL15 - pointer zero readable at d6
// RL16 - stop refused unless unlock key present
// RL17 - stop halts, keeps all register contents
// RL18 - 8-bit operands, indirect fetches address first
module cssb_exec #(
  parameter bit BANK1_EN = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic instr_valid,
  input wire logic [7:0] instr_op,
  input wire logic [7:0] instr_b1,
  input wire logic [7:0] instr_b2,
  output logic instr_ready,
  output logic instr_done,
  output logic instr_fault,
  output logic stop_mode,
  output logic bank_sel
);
  localparam int AW = 9;
  localparam cssb_pkg::cssb_state_t st_idle = cssb_pkg::st_idle;
  localparam cssb_pkg::cssb_state_t st_ind = cssb_pkg::st_ind;
  localparam cssb_pkg::cssb_state_t st_ind_cap = cssb_pkg::st_ind_cap;
  localparam cssb_pkg::cssb_state_t st_src = cssb_pkg::st_src;
  localparam cssb_pkg::cssb_state_t st_src_cap = cssb_pkg::st_src_cap;
  localparam cssb_pkg::cssb_state_t st_dst = cssb_pkg::st_dst;
  localparam cssb_pkg::cssb_state_t st_dst_cap = cssb_pkg::st_dst_cap;
  localparam cssb_pkg::cssb_state_t st_wb = cssb_pkg::st_wb;
  localparam cssb_pkg::cssb_state_t st_hold = cssb_pkg::st_hold;
  localparam cssb_pkg::cssb_state_t st_stopped = cssb_pkg::st_stopped;

  cssb_mem_if #(.AW(AW)) mem_bus ();

  cssb_regmem #(.AW(AW)) u_mem (
    .clk(clk),
    .mp(mem_bus)
  );

  cssb_pkg::cssb_state_t state_q, state_d;
  cssb_pkg::cssb_byte_t flags_q, flags_d;
  cssb_pkg::cssb_byte_t rp0_q, rp0_d;
  cssb_pkg::cssb_byte_t rp1_q, rp1_d;
  cssb_pkg::cssb_byte_t unlock_q, unlock_d;
  cssb_pkg::cssb_byte_t op_q, op_d;
  cssb_pkg::cssb_byte_t b1_q, b1_d;
  cssb_pkg::cssb_byte_t src_addr_q, src_addr_d;
  cssb_pkg::cssb_byte_t dst_addr_q, dst_addr_d;
  cssb_pkg::cssb_byte_t src_q, src_d;
  cssb_pkg::cssb_byte_t dst_q, dst_d;
  logic [3:0] cnt_q, cnt_d;
  logic done_d, fault_d;
  logic done_q, fault_q, ready_q;
  logic sp_hit_q;
  logic stop_q;
  cssb_pkg::cssb_byte_t sp_val_q;

  function automatic logic [7:0] wreg_addr(input logic [3:0] r,
      input logic [7:0] p0, input logic [7:0] p1);
    wreg_addr = r[3] ? {p1[7:3], r[2:0]} : {p0[7:3], r[2:0]};
  endfunction : wreg_addr

  // an address with the working prefix names a working register
  function automatic logic [7:0] reg_addr(input logic [7:0] a,
      input logic [7:0] p0, input logic [7:0] p1);
    if (a[7:4] == `CSSB_WREG_HI) begin
      reg_addr = wreg_addr(a[3:0], p0, p1);
    end else begin
      reg_addr = a;
    end
  endfunction : reg_addr

  // exec side port requests
  logic ex_re, ex_we, ex_flag_we, ex_rp0_we, ex_rp1_we;
  cssb_pkg::cssb_byte_t ex_raddr, ex_waddr, ex_wdata, ex_flags;
  cssb_pkg::cssb_byte_t ex_rp0, ex_rp1;

  // bus always wins the port; exec stalls so the master never waits
  wire bus_busy = bus_wr | bus_rd;
  wire rd_en = bus_rd | (ex_re & ~bus_busy);
  wire wr_en = bus_wr | (ex_we & ~bus_busy);
  wire [7:0] rd_addr = bus_rd ? bus_addr : ex_raddr;
  wire [7:0] wr_addr = bus_wr ? bus_addr : ex_waddr;
  wire [7:0] wr_data = bus_wr ? bus_wdata : ex_wdata;

  wire rd_flags = rd_addr == `CSSB_ADDR_FLAGS;
  wire rd_rp0 = rd_addr == `CSSB_ADDR_RP0;
  wire rd_rp1 = rd_addr == `CSSB_ADDR_RP1;
  wire rd_unlock = rd_addr == `CSSB_ADDR_UNLOCK;
  wire rd_sp = rd_flags | rd_rp0 | rd_rp1 | rd_unlock;
  wire wr_flags = wr_en & (wr_addr == `CSSB_ADDR_FLAGS);
  wire wr_rp0 = wr_en & (wr_addr == `CSSB_ADDR_RP0);
  wire wr_rp1 = wr_en & (wr_addr == `CSSB_ADDR_RP1);
  wire wr_unlock = wr_en & (wr_addr == `CSSB_ADDR_UNLOCK);
  wire wr_sp = wr_flags | wr_rp0 | wr_rp1 | wr_unlock;

  wire [7:0] sp_val = rd_flags ? flags_q :
                      rd_rp0 ? rp0_q :
                      rd_rp1 ? rp1_q : unlock_q; // see RL15

  // bank 1 is an extra copy of the set 1 area, high half of memory
  wire bank_hi = BANK1_EN & flags_q[`CSSB_FLAG_BANK];
  wire rd_set1 = rd_addr[7:6] == `CSSB_SET1_HI;
  wire wr_set1 = wr_addr[7:6] == `CSSB_SET1_HI;
  assign mem_bus.re = rd_en & ~rd_sp;
  assign mem_bus.raddr = {bank_hi & rd_set1, rd_addr}; // see RL3
  assign mem_bus.we = wr_en & ~wr_sp;
  assign mem_bus.waddr = {bank_hi & wr_set1, wr_addr}; // see RL3
  assign mem_bus.wdata = wr_data;

  wire [7:0] rd_data = sp_hit_q ? sp_val_q : mem_bus.rdata;

  // arithmetic, 8-bit operands only
  wire carry = flags_q[`CSSB_FLAG_C];
  wire [8:0] sub_full = {1'b0, dst_q} - {1'b0, src_q} - {8'h00, carry}; // see RL4
  wire [4:0] sub_lo = {1'b0, dst_q[3:0]} - {1'b0, src_q[3:0]} -
                      {4'h0, carry}; // see RL8
  wire [7:0] sub_res = sub_full[7:0];
  wire sub_v = (dst_q[7] != src_q[7]) & (sub_res[7] == src_q[7]); // see RL7
  wire [7:0] asr_res = {dst_q[7], dst_q[7:1]}; // see RL10

  wire is_sbc = (op_q >= `CSSB_OP_SBC_R_R) & (op_q <= `CSSB_OP_SBC_G_IM);
  wire is_asr = (op_q == `CSSB_OP_ASR_G) | (op_q == `CSSB_OP_ASR_IG);
  wire long_form = is_sbc & (op_q != `CSSB_OP_SBC_R_R);
  wire [3:0] need = long_form ? `CSSB_CYC_LONG : `CSSB_CYC_SHORT;
  wire unlocked = unlock_q == `CSSB_UNLOCK_KEY;

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    b1_d = b1_q;
    src_addr_d = src_addr_q;
    dst_addr_d = dst_addr_q;
    src_d = src_q;
    dst_d = dst_q;
    cnt_d = (state_q == st_idle || cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
    done_d = 1'b0;
    fault_d = 1'b0;
    ex_re = 1'b0;
    ex_raddr = src_addr_q;
    ex_we = 1'b0;
    ex_waddr = dst_addr_q;
    ex_wdata = sub_res;
    ex_flag_we = 1'b0;
    ex_flags = flags_q;
    ex_rp0_we = 1'b0;
    ex_rp1_we = 1'b0;
    ex_rp0 = rp0_q;
    ex_rp1 = rp1_q;
    case (state_q)
      st_idle: begin
        if (instr_valid) begin
          op_d = instr_op;
          b1_d = instr_b1;
          cnt_d = 4'h1;
          state_d = st_wb;
          case (instr_op)
            `CSSB_OP_SBC_R_R, `CSSB_OP_SBC_R_IR: begin
              dst_addr_d = wreg_addr(instr_b1[7:4], rp0_q, rp1_q);
              src_addr_d = wreg_addr(instr_b1[3:0], rp0_q, rp1_q);
              state_d = (instr_op == `CSSB_OP_SBC_R_R) ? st_src : st_ind;
            end
            `CSSB_OP_SBC_G_G, `CSSB_OP_SBC_G_IG: begin
              src_addr_d = reg_addr(instr_b1, rp0_q, rp1_q);
              dst_addr_d = reg_addr(instr_b2, rp0_q, rp1_q);
              state_d = (instr_op == `CSSB_OP_SBC_G_G) ? st_src : st_ind;
            end
            `CSSB_OP_SBC_G_IM: begin
              dst_addr_d = reg_addr(instr_b1, rp0_q, rp1_q);
              src_d = instr_b2;
              state_d = st_dst;
            end
            `CSSB_OP_ASR_G, `CSSB_OP_ASR_IG: begin
              dst_addr_d = reg_addr(instr_b1, rp0_q, rp1_q);
              state_d = (instr_op == `CSSB_OP_ASR_G) ? st_dst : st_ind;
            end
            `CSSB_OP_SEL_BANK0, `CSSB_OP_SEL_BANK1, `CSSB_OP_SET_CARRY,
            `CSSB_OP_LOAD_PTR, `CSSB_OP_STOP: begin
              state_d = st_wb;
            end
            default: begin
              fault_d = 1'b1;
              state_d = st_idle;
            end
          endcase
        end
      end
      st_ind: begin
        ex_re = 1'b1;
        ex_raddr = is_asr ? dst_addr_q : src_addr_q;
        if (!bus_busy) begin
          state_d = st_ind_cap;
        end
      end
      st_ind_cap: begin
        // pointer byte is a full address, no working-register mapping
        if (is_asr) begin
          dst_addr_d = rd_data; // see RL18
          state_d = st_dst;
        end else begin
          src_addr_d = rd_data; // see RL18
          state_d = st_src;
        end
      end
      st_src: begin
        ex_re = 1'b1;
        if (!bus_busy) begin
          state_d = st_src_cap;
        end
      end
      st_src_cap: begin
        src_d = rd_data;
        state_d = st_dst;
      end
      st_dst: begin
        ex_re = 1'b1;
        ex_raddr = dst_addr_q;
        if (!bus_busy) begin
          state_d = st_dst_cap;
        end
      end
      st_dst_cap: begin
        dst_d = rd_data;
        state_d = st_wb;
      end
      st_wb: begin
        if (!bus_busy) begin
          state_d = st_hold;
          ex_flag_we = 1'b1;
          case (op_q)
            `CSSB_OP_SEL_BANK0: begin
              ex_flags[`CSSB_FLAG_BANK] = 1'b0; // see RL1
            end
            `CSSB_OP_SEL_BANK1: begin
              ex_flags[`CSSB_FLAG_BANK] = 1'b1; // see RL2
            end
            `CSSB_OP_SET_CARRY: begin
              ex_flags[`CSSB_FLAG_C] = 1'b1; // see RL9
            end
            `CSSB_OP_ASR_G, `CSSB_OP_ASR_IG: begin
              ex_we = 1'b1;
              ex_wdata = asr_res; // see RL10
              ex_flags[`CSSB_FLAG_C] = dst_q[0]; // see RL11
              ex_flags[`CSSB_FLAG_Z] = asr_res == 8'h00; // see RL11
              ex_flags[`CSSB_FLAG_S] = asr_res[7]; // see RL11
              ex_flags[`CSSB_FLAG_V] = 1'b0; // see RL12
            end
            `CSSB_OP_LOAD_PTR: begin
              ex_flag_we = 1'b0;
              case (b1_q[1:0])
                2'h2: begin
                  ex_rp0_we = 1'b1;
                  ex_rp0 = {b1_q[7:3], rp0_q[2:0]}; // see RL13
                end
                2'h1: begin
                  ex_rp1_we = 1'b1;
                  ex_rp1 = {b1_q[7:3], rp1_q[2:0]}; // see RL13
                end
                2'h0: begin
                  ex_rp0_we = 1'b1;
                  ex_rp1_we = 1'b1;
                  ex_rp0 = {b1_q[7:4], 1'b0, rp0_q[2:0]}; // see RL14
                  ex_rp1 = {b1_q[7:4], 1'b1, rp1_q[2:0]}; // see RL14
                end
                default: begin
                  // code 11 selects no pointer: nothing is written
                  ex_rp0_we = 1'b0;
                end
              endcase
            end
            `CSSB_OP_STOP: begin
              ex_flag_we = 1'b0;
              if (unlocked) begin
                state_d = st_stopped; // see RL17
              end else begin
                fault_d = 1'b1; // see RL16
                state_d = st_idle;
              end
            end
            default: begin
              // borrow subtract, all operand forms
              ex_we = 1'b1; // see RL4
              ex_wdata = sub_res;
              ex_flags[`CSSB_FLAG_C] = sub_full[8]; // see RL5
              ex_flags[`CSSB_FLAG_Z] = sub_res == 8'h00; // see RL6
              ex_flags[`CSSB_FLAG_S] = sub_res[7]; // see RL6
              ex_flags[`CSSB_FLAG_V] = sub_v; // see RL7
              ex_flags[`CSSB_FLAG_D] = 1'b1; // see RL8
              ex_flags[`CSSB_FLAG_H] = sub_lo[4]; // see RL8
            end
          endcase
        end
      end
      st_hold: begin
        if (cnt_q >= need - 4'h1) begin
          done_d = 1'b1;
          state_d = st_idle;
        end
      end
      st_stopped: begin
        // only reset leaves stop mode; memory and registers are kept
        state_d = st_stopped; // see RL17
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  // a register write lands after the instruction's own flag update
  always_comb begin
    flags_d = (ex_flag_we & ~bus_busy) ? ex_flags : flags_q;
    flags_d = wr_flags ? wr_data : flags_d;
    rp0_d = ex_rp0_we ? ex_rp0 : rp0_q;
    rp0_d = wr_rp0 ? wr_data : rp0_d; // see RL15
    rp1_d = ex_rp1_we ? ex_rp1 : rp1_q;
    rp1_d = wr_rp1 ? wr_data : rp1_d;
    unlock_d = wr_unlock ? wr_data : unlock_q; // see RL16
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= st_idle;
      flags_q <= `CSSB_RST_FLAGS;
      rp0_q <= `CSSB_RST_RP0;
      rp1_q <= `CSSB_RST_RP1;
      unlock_q <= `CSSB_RST_UNLOCK;
      stop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      flags_q <= flags_d;
      rp0_q <= rp0_d;
      rp1_q <= rp1_d;
      unlock_q <= unlock_d;
      stop_q <= state_d == st_stopped; // see RL17
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_q <= 8'h00;
      b1_q <= 8'h00;
      src_addr_q <= 8'h00;
      dst_addr_q <= 8'h00;
      src_q <= 8'h00;
      dst_q <= 8'h00;
      cnt_q <= 4'h0;
    end else begin
      op_q <= op_d;
      b1_q <= b1_d;
      src_addr_q <= src_addr_d;
      dst_addr_q <= dst_addr_d;
      src_q <= src_d;
      dst_q <= dst_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      fault_q <= 1'b0;
      ready_q <= 1'b0;
      sp_hit_q <= 1'b0;
      sp_val_q <= 8'h00;
    end else begin
      done_q <= done_d;
      fault_q <= fault_d;
      ready_q <= state_d == st_idle;
      sp_hit_q <= rd_en & rd_sp;
      sp_val_q <= sp_val;
    end
  end

  // memory data come from the store's own output register
  assign bus_rdata = rd_data;
  assign instr_ready = ready_q;
  assign instr_done = done_q;
  assign instr_fault = fault_q;
  assign stop_mode = stop_q;
  assign bank_sel = flags_q[`CSSB_FLAG_BANK];
endmodule : cssb_exec
`default_nettype wire

//--- test/cssb_exec_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "cssb_params.svh"
module cssb_exec_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic instr_valid,
  input wire logic [7:0] instr_op,
  input wire logic [7:0] instr_b1,
  input wire logic [7:0] instr_b2,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic instr_fault,
  input wire logic stop_mode,
  input wire logic bank_sel
);
  logic [7:0] op_q;
  logic [7:0] key_q;
  wire take = instr_valid && instr_ready;
  wire key_ok = key_q == `CSSB_UNLOCK_KEY;
  wire short_op = instr_op == `CSSB_OP_SEL_BANK0 ||
    instr_op == `CSSB_OP_SEL_BANK1 || instr_op == `CSSB_OP_SET_CARRY;
  wire stop_op = instr_op == `CSSB_OP_STOP;
  // shadow of the unlock byte, so the stop guard can be judged at the ports
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      op_q <= 8'h00;
      key_q <= `CSSB_RST_UNLOCK;
    end else begin
      if (take) op_q <= instr_op;
      if (bus_wr && bus_addr == `CSSB_ADDR_UNLOCK) key_q <= bus_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence short_take; take && short_op; endsequence
  sequence short_end; ##[3:4] instr_done; endsequence
  short_time_a: assert property (short_take |-> short_end)
    else $error("short op did not finish in four cycles");
  bank_zero_a: assert property (
    instr_done && op_q == `CSSB_OP_SEL_BANK0 |=> !bank_sel)
    else $error("bank flag not cleared");
  bank_one_a: assert property (
    instr_done && op_q == `CSSB_OP_SEL_BANK1 |=> bank_sel)
    else $error("bank flag not set");
  stop_refuse_a: assert property (take && stop_op && !key_ok |-> ##2 instr_fault)
    else $error("locked stop not refused");
  stop_enter_a: assert property (take && stop_op && key_ok |-> ##[1:8] stop_mode)
    else $error("unlocked stop not entered");
  stop_hold_a: assert property (stop_mode |=> stop_mode && !instr_ready)
    else $error("stop mode left without reset");
  busy_after_take_a: assert property (
    take |=> !instr_ready || instr_fault)
    else $error("ready high after take");
  ready_back_a: assert property ((instr_done || instr_fault) |-> instr_ready)
    else $error("ready not back with completion");
  done_pulse_a: assert property (instr_done |=> !instr_done)
    else $error("done longer than one cycle");
  done_fault_a: assert property (!(instr_done && instr_fault))
    else $error("done and fault together");
  reset_clears_a: assert property (disable iff (1'b0)
    !reset_n |=> !instr_ready && !stop_mode && !bank_sel)
    else $error("reset left state behind");
endmodule : cssb_exec_checker
bind cssb_exec cssb_exec_checker chk_u (.clk(clk), .reset_n(reset_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .instr_valid(instr_valid),
  .instr_op(instr_op), .instr_b1(instr_b1), .instr_b2(instr_b2),
  .instr_ready(instr_ready), .instr_done(instr_done),
  .instr_fault(instr_fault), .stop_mode(stop_mode), .bank_sel(bank_sel));
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cssb_params.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  mismatches++; $display("unexpected %s: expected %h, seen %h", nm, ex, got); \
  end end
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic instr_valid = 1'b0;
  logic [7:0] instr_op = 8'h00;
  logic [7:0] instr_b1 = 8'h00;
  logic [7:0] instr_b2 = 8'h00;
  logic instr_ready, instr_done, instr_fault, stop_mode, bank_sel;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [15:0] e16;
  logic [7:0] da, sa;
  logic [7:0] vd [4] = '{8'h20, 8'h20, 8'h05, 8'h80};
  logic [7:0] vs [4] = '{8'h03, 8'h8a, 8'h05, 8'h01};
  logic vc [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0] pv [4] = '{8'h40, 8'h52, 8'h69, 8'hf3};
  logic [7:0] p0 [4] = '{8'h40, 8'h50, 8'h50, 8'h50};
  logic [7:0] p1 [4] = '{8'h48, 8'h48, 8'h68, 8'h68};

  cssb_exec dut_u (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_b1(instr_b1), .instr_b2(instr_b2), .instr_ready(instr_ready),
    .instr_done(instr_done), .instr_fault(instr_fault),
    .stop_mode(stop_mode), .bank_sel(bank_sel));

  always #25 clk = ~clk;

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // a hung engine never raises done, so cut the run short here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, string nm);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(nm, e, bus_rdata)
  endtask : rdchk

  task automatic run(input logic [7:0] op, input logic [7:0] b1,
      input logic [7:0] b2, input logic ef);
    int n;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_b1 <= b1;
    instr_b2 <= b2;
    @(posedge clk);
    instr_valid <= 1'b0;
    n = 0;
    #1;
    while (n < 20 && instr_done !== 1'b1 && instr_fault !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("fault", ef, instr_fault)
    `CHK("done", (op != `CSSB_OP_STOP) && !ef, instr_done)
  endtask : run

  function automatic logic [15:0] sbc_ref(input logic [7:0] d,
      input logic [7:0] s, input logic c);
    logic [8:0] r;
    logic h;
    logic v;
    r = {1'b0, d} - {1'b0, s} - 9'(c);
    h = {1'b0, d[3:0]} < ({1'b0, s[3:0]} + 5'(c));
    v = (d[7] != s[7]) && (r[7] == s[7]);
    return {r[7:0], r[8], r[7:0] == 8'h00, r[7], v, 1'b1, h, 2'b00};
  endfunction : sbc_ref

  initial begin
    do_reset();
    rdchk(8'hd6, `CSSB_RST_RP0, "ptr0");
    rdchk(8'hd7, `CSSB_RST_RP1, "ptr1");
    `CHK("bank", 1'b0, bank_sel)
    $display("test reset done");
    for (int f = 0; f < 5; f++) begin
      da = (f < 2) ? 8'hc1 : 8'h11;
      sa = (f < 2) ? 8'hc2 : 8'h12;
      wr(8'hd5, 8'h80);
      wr(da, 8'h20);
      wr(sa, (f == 1 || f == 3) ? 8'h30 : 8'h03);
      wr(8'h30, 8'h03);
      run(8'(8'h32 + f), (f == 4) ? 8'h11 : 8'h12,
        (f == 4) ? 8'h03 : 8'h11, 1'b0);
      rdchk(da, 8'h1c, "sbc form");
      rdchk(sa, (f == 1 || f == 3) ? 8'h30 : 8'h03, "sbc src");
    end
    for (int i = 0; i < 4; i++) begin
      e16 = sbc_ref(vd[i], vs[i], vc[i]);
      wr(8'hd5, {vc[i], 7'h00});
      wr(8'h11, vd[i]);
      run(8'h36, 8'h11, vs[i], 1'b0);
      rdchk(8'h11, e16[15:8], "sbc value");
      rdchk(8'hd5, e16[7:0], "sbc flags");
    end
    $display("test subtract done");
    wr(8'hd5, 8'h9c);
    wr(8'h10, 8'h9a);
    run(8'hd0, 8'h10, 8'h00, 1'b0);
    rdchk(8'h10, 8'hcd, "shift value");
    rdchk(8'hd5, 8'h2c, "shift flags");
    wr(8'hd5, 8'h00);
    wr(8'h12, 8'h13);
    wr(8'h13, 8'h01);
    run(8'hd1, 8'h12, 8'h00, 1'b0);
    rdchk(8'h13, 8'h00, "shift ind");
    rdchk(8'hd5, 8'hc0, "shift ind flags");
    rdchk(8'h12, 8'h13, "shift ptr");
    wr(8'hd5, 8'h54);
    run(`CSSB_OP_SET_CARRY, 8'h00, 8'h00, 1'b0);
    rdchk(8'hd5, 8'hd4, "carry set");
    $display("test shift and carry done");
    wr(8'hd5, 8'hf4);
    run(`CSSB_OP_SEL_BANK1, 8'h00, 8'h00, 1'b0);
    `CHK("bank", 1'b1, bank_sel)
    rdchk(8'hd5, 8'hf5, "flags bank1");
    wr(8'he0, 8'h22);
    run(`CSSB_OP_SEL_BANK0, 8'h00, 8'h00, 1'b0);
    rdchk(8'hd5, 8'hf4, "flags bank0");
    wr(8'he0, 8'h11);
    run(`CSSB_OP_SEL_BANK1, 8'h00, 8'h00, 1'b0);
    rdchk(8'he0, 8'h22, "bank1 byte");
    run(`CSSB_OP_SEL_BANK0, 8'h00, 8'h00, 1'b0);
    rdchk(8'he0, 8'h11, "bank0 byte");
    $display("test banks done");
    wr(8'hd5, 8'hfc);
    for (int i = 0; i < 4; i++) begin
      run(`CSSB_OP_LOAD_PTR, pv[i], 8'h00, 1'b0);
      rdchk(`CSSB_ADDR_RP0, p0[i], "ptr0 load");
      rdchk(`CSSB_ADDR_RP1, p1[i], "ptr1 load");
    end
    rdchk(8'hd5, 8'hfc, "ptr flags");
    run(8'h00, 8'h00, 8'h00, 1'b1);
    $display("test pointers done");
    run(`CSSB_OP_STOP, 8'h00, 8'h00, 1'b1);
    wr(`CSSB_ADDR_UNLOCK, 8'ha4);
    run(`CSSB_OP_STOP, 8'h00, 8'h00, 1'b1);
    `CHK("stop", 1'b0, stop_mode)
    wr(`CSSB_ADDR_UNLOCK, `CSSB_UNLOCK_KEY);
    run(`CSSB_OP_STOP, 8'h00, 8'h00, 1'b0);
    `CHK("stop", 1'b1, stop_mode)
    `CHK("ready", 1'b0, instr_ready)
    @(posedge clk);
    do_reset();
    #1;
    `CHK("stop", 1'b0, stop_mode)
    `CHK("ready", 1'b1, instr_ready)
    $display("test stop done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
